// ---- hdl/hrs_pkg.sv ----
package hrs_pkg;
	// Clock
	localparam int CLK_HZ              = 25000000;
	// Times in their own units
	localparam int T_RECOVERY_US       = 500;
	localparam int T_EEPROM_MAX_US     = 99500;
	localparam int T_ATTACH_MAX_MS     = 100;
	localparam int T_REQUEST_MAX_MS    = 5;
	localparam int T_BUSPWR_LOAD_US    = 99500;
	// Derived cycle counts; every division is exact at 25 MHz, so none round
	localparam int RECOVERY_CYC        = (CLK_HZ / 1000000) * T_RECOVERY_US;
	localparam int EEPROM_MAX_CYC      = (CLK_HZ / 1000000) * T_EEPROM_MAX_US;
	localparam int ATTACH_MAX_CYC      = (CLK_HZ / 1000) * T_ATTACH_MAX_MS;
	localparam int REQUEST_MAX_CYC     = (CLK_HZ / 1000) * T_REQUEST_MAX_MS;
	localparam int BUSPWR_LOAD_CYC     = (CLK_HZ / 1000000) * T_BUSPWR_LOAD_US;
	// Field layout and reset values
	localparam int NUM_PORTS           = 3;
	localparam int ADDR_W              = 7;
	localparam int CNT_W               = 32;
	localparam logic [6:0] DEFAULT_ADDR = 7'h00;
	localparam logic [2:0] PORT_PWR_OFF = 3'h0;

	typedef enum logic [2:0] {
		HRS_RECOVER   = 3'b000,
		HRS_EEPROM    = 3'b001,
		HRS_SMB_WAIT  = 3'b010,
		HRS_APPLY     = 3'b011,
		HRS_ATTACHED  = 3'b100,
		HRS_FAULT     = 3'b101
	} hrs_state_e;
endpackage

// ---- hdl/hrs_timer.sv ----
`timescale 1ns/1ps
module hrs_timer
	import hrs_pkg::*;
#(
	parameter int WIDTH = 32
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             restart,
	input  wire logic [WIDTH-1:0] limit,
	output logic                  expired
);
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	logic             expired_r;
	logic             expired_nxt;

	always_comb
	begin
		count_nxt = count_r;
		expired_nxt = expired_r;
		if (restart)
		begin
			count_nxt = '0;
			expired_nxt = 1'b0;
		end
		else if (!expired_r)
		begin
			// Saturate so a long wait cannot wrap into a false expiry
			if (count_r + 1'b1 >= limit)
				expired_nxt = 1'b1;
			else
				count_nxt = count_r + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_r <= '0;
			expired_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			expired_r <= expired_nxt;
		end
	end

	assign expired = expired_r;
endmodule

// ---- hdl/hrs_sequencer.sv ----
`timescale 1ns/1ps
module hrs_sequencer
	import hrs_pkg::*;
#(
	parameter int RECOVERY_CYCLES   = RECOVERY_CYC,
	parameter int EEPROM_MAX_CYCLES = EEPROM_MAX_CYC,
	parameter int ATTACH_MAX_CYCLES = ATTACH_MAX_CYC,
	parameter int REQUEST_CYCLES    = REQUEST_MAX_CYC,
	parameter int BUSPWR_CYCLES     = BUSPWR_LOAD_CYC
)
(
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 smbusModeSel,
	input  wire logic                 selfPowered,
	input  wire logic                 eepromDone,
	input  wire logic                 smbusLoadDone,
	input  wire logic                 applyDone,
	input  wire logic                 usbBusReset,
	input  wire logic                 suspendReq,
	input  wire logic                 setAddrValid,
	input  wire logic [ADDR_W-1:0]    setAddrValue,
	input  wire logic                 setConfig,
	input  wire logic                 portPowerReq,
	input  wire logic                 requestStart,
	input  wire logic                 requestDone,
	output logic                      operational,
	output logic                      eepromFetch,
	output logic                      smbusEnable,
	output logic                      applyConfig,
	output logic                      usbAttach,
	output logic                      configFault,
	output logic [ADDR_W-1:0]         deviceAddr,
	output logic                      configured,
	output logic [NUM_PORTS-1:0]      downstream_port_power_en,
	output logic                      ttFlush,
	output logic                      suspended,
	output logic                      requestTimeout,
	output logic                      downstreamReset
);
	hrs_state_e          state_r;
	hrs_state_e          state_nxt;
	logic                restart;
	logic [CNT_W-1:0]    limit;
	logic                expired;
	logic [ADDR_W-1:0]   addr_r;
	logic [ADDR_W-1:0]   addr_nxt;
	logic                cfg_r;
	logic                cfg_nxt;
	logic [NUM_PORTS-1:0] pwr_r;
	logic [NUM_PORTS-1:0] pwr_nxt;
	logic                flush_r;
	logic                flush_nxt;
	logic                susp_r;
	logic                susp_nxt;
	logic                reqBusy_r;
	logic                reqBusy_nxt;
	logic                reqTo_r;
	logic                reqTo_nxt;
	logic                fault_r;
	logic                fault_nxt;
	logic                reqRestart;
	logic                reqExpired;

	// Phase timer; restarted on every state change
	hrs_timer #(.WIDTH(CNT_W)) phaseTimer (
		.clk     (clk),
		.reset   (reset),
		.restart (restart),
		.limit   (limit),
		.expired (expired)
	);

	// Request completion watchdog
	hrs_timer #(.WIDTH(CNT_W)) reqTimer (
		.clk     (clk),
		.reset   (reset),
		.restart (reqRestart),
		.limit   (CNT_W'(REQUEST_CYCLES)),
		.expired (reqExpired)
	);

	always_comb
	begin
		state_nxt = state_r;
		fault_nxt = fault_r;
		limit = CNT_W'(RECOVERY_CYCLES);
		unique case (state_r)
			HRS_RECOVER:
			begin
				limit = CNT_W'(RECOVERY_CYCLES);
				if (expired)
					state_nxt = smbusModeSel ? HRS_SMB_WAIT : HRS_EEPROM;
			end
			HRS_EEPROM:
			begin
				limit = CNT_W'(EEPROM_MAX_CYCLES);
				if (eepromDone)
					state_nxt = HRS_APPLY;
				else if (expired)
				begin
					// Give up on a dead EEPROM and attach with defaults
					fault_nxt = 1'b1;
					state_nxt = HRS_APPLY;
				end
			end
			HRS_SMB_WAIT:
			begin
				limit = CNT_W'(BUSPWR_CYCLES);
				if (smbusLoadDone)
					state_nxt = HRS_APPLY;
				else if (!selfPowered && expired)
				begin
					fault_nxt = 1'b1;
					state_nxt = HRS_APPLY;
				end
			end
			HRS_APPLY:
			begin
				limit = CNT_W'(ATTACH_MAX_CYCLES);
				// Attach on apply done, or forced at the deadline
				if (applyDone || expired)
					state_nxt = HRS_ATTACHED;
			end
			HRS_ATTACHED:
				limit = CNT_W'(ATTACH_MAX_CYCLES);
			default:
				state_nxt = HRS_RECOVER;
		endcase
		restart = (state_nxt != state_r);
	end

	always_comb
	begin
		addr_nxt = addr_r;
		cfg_nxt = cfg_r;
		pwr_nxt = pwr_r;
		flush_nxt = 1'b0;
		susp_nxt = susp_r;
		reqBusy_nxt = reqBusy_r;
		reqTo_nxt = 1'b0;
		reqRestart = 1'b1;
		if (state_r == HRS_ATTACHED)
		begin
			if (usbBusReset)
			begin
				addr_nxt = DEFAULT_ADDR;
				cfg_nxt = 1'b0;
				pwr_nxt = PORT_PWR_OFF;
				flush_nxt = 1'b1;
				susp_nxt = 1'b0;
				reqBusy_nxt = 1'b0;
			end
			else
			begin
				if (setAddrValid)
					addr_nxt = setAddrValue;
				if (setConfig)
					cfg_nxt = 1'b1;
				if (cfg_r)
					pwr_nxt = {NUM_PORTS{portPowerReq}};
				susp_nxt = suspendReq;
				if (requestStart)
					reqBusy_nxt = 1'b1;
				else if (requestDone)
					reqBusy_nxt = 1'b0;
				if (reqBusy_r && !requestDone)
					reqRestart = 1'b0;
				if (reqBusy_r && reqExpired)
				begin
					reqTo_nxt = 1'b1;
					reqBusy_nxt = 1'b0;
				end
			end
		end
	end

	// Async reset takes the state machine back to recovery
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= HRS_RECOVER;
			fault_r <= 1'b0;
			addr_r <= DEFAULT_ADDR;
			cfg_r <= 1'b0;
			pwr_r <= PORT_PWR_OFF;
			flush_r <= 1'b0;
			susp_r <= 1'b0;
			reqBusy_r <= 1'b0;
			reqTo_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			fault_r <= fault_nxt;
			addr_r <= addr_nxt;
			cfg_r <= cfg_nxt;
			pwr_r <= pwr_nxt;
			flush_r <= flush_nxt;
			susp_r <= susp_nxt;
			reqBusy_r <= reqBusy_nxt;
			reqTo_r <= reqTo_nxt;
		end
	end

	logic op_r;
	logic fetch_r;
	logic smbEn_r;
	logic apply_r;
	logic attach_r;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			op_r <= 1'b0;
			fetch_r <= 1'b0;
			smbEn_r <= 1'b0;
			apply_r <= 1'b0;
			attach_r <= 1'b0;
		end
		else
		begin
			op_r <= (state_nxt != HRS_RECOVER);
			fetch_r <= (state_nxt == HRS_EEPROM);
			smbEn_r <= (state_nxt == HRS_SMB_WAIT);
			apply_r <= (state_nxt == HRS_APPLY);
			attach_r <= (state_nxt == HRS_ATTACHED);
		end
	end

	assign operational = op_r;
	assign eepromFetch = fetch_r;
	assign smbusEnable = smbEn_r;
	assign applyConfig = apply_r;
	assign usbAttach = attach_r;
	assign configFault = fault_r;
	assign deviceAddr = addr_r;
	assign configured = cfg_r;
	assign downstream_port_power_en = pwr_r;
	assign ttFlush = flush_r;
	assign suspended = susp_r;
	assign requestTimeout = reqTo_r;
	// Upstream reset never reaches downstream ports
	assign downstreamReset = 1'b0;
endmodule

// ---- bench/hrs_sequencer_properties.sv ----
`timescale 1ns/1ps
module hrs_sequencer_chk
	import hrs_pkg::*;
#(
	parameter int EEPROM_MAX_CYCLES = 200,
	parameter int ATTACH_MAX_CYCLES = 200
)
(
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       usbBusReset,
	input wire logic       usbAttach,
	input wire logic       eepromFetch,
	input wire logic       applyConfig,
	input wire logic [6:0] deviceAddr,
	input wire logic       configured,
	input wire logic [2:0] downstream_port_power_en,
	input wire logic       ttFlush,
	input wire logic       suspended,
	input wire logic       downstreamReset
);
	// Phases far too long for delay ranges
	logic [31:0] eCnt;
	logic [31:0] aCnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			eCnt <= 32'h0;
			aCnt <= 32'h0;
		end
		else
		begin
			eCnt <= eepromFetch ? eCnt + 32'h1 : 32'h0;
			aCnt <= applyConfig ? aCnt + 32'h1 : 32'h0;
		end
	end
	a_no_forward: assert property (downstreamReset == 1'b0) else $error("reset forwarded");
	a_reset_addr: assert property (usbAttach && usbBusReset |=> deviceAddr == DEFAULT_ADDR) else $error("addr");
	a_reset_unconf: assert property (usbAttach && usbBusReset |=> !configured) else $error("configured");
	a_reset_power: assert property (usbAttach && usbBusReset |=> downstream_port_power_en == PORT_PWR_OFF)
		else $error("power");
	a_reset_flush: assert property ($rose(usbBusReset) && usbAttach |=> ttFlush) else $error("flush");
	a_reset_wake: assert property (usbAttach && usbBusReset |=> !suspended) else $error("suspended");
	a_attach_gated: assert property ($rose(usbAttach) |-> $past(applyConfig)) else $error("early attach");
	a_eeprom_time: assert property (eCnt <= EEPROM_MAX_CYCLES + 2) else $error("eeprom phase");
	a_apply_time: assert property (aCnt <= ATTACH_MAX_CYCLES + 2) else $error("apply phase");
endmodule
bind hrs_sequencer hrs_sequencer_chk #(.EEPROM_MAX_CYCLES(EEPROM_MAX_CYCLES), .ATTACH_MAX_CYCLES(ATTACH_MAX_CYCLES))
	hrs_sequencer_chk_inst (.*);

// ---- bench/hrs_far_end.sv ----
`timescale 1ns/1ps
module hrs_far_end
#(
	parameter int HOST_WAIT = 30
)
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        eepromFetch,
	input wire logic        smbusEnable,
	input wire logic        applyConfig,
	input wire logic        usbAttach,
	input wire logic [15:0] loadDelay,
	input wire logic        hostResetEn,
	output logic            eepromDone,
	output logic            smbusLoadDone,
	output logic            applyDone,
	output logic            usbBusReset
);
	logic [3:0]  phase_r;
	logic [15:0] cnt_r;
	wire  [3:0]  phase = {eepromFetch, smbusEnable, applyConfig, usbAttach};
	wire         fresh = (phase != phase_r);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			phase_r <= 4'h0;
			cnt_r   <= 16'h0;
		end
		else
		begin
			phase_r <= phase;
			cnt_r   <= fresh ? 16'h0 : cnt_r + 16'h1;
		end
	end
	// Over-long loads only when the bench asks
	// Count still belongs to the old phase on a phase's first cycle
	assign eepromDone    = eepromFetch && !fresh && cnt_r >= loadDelay;
	assign smbusLoadDone = smbusEnable && !fresh && cnt_r >= loadDelay;
	assign applyDone     = applyConfig && !fresh && cnt_r >= 16'h3;
	assign usbBusReset   = hostResetEn && usbAttach && !fresh && cnt_r >= 16'(HOST_WAIT);
endmodule

// ---- bench/hrs_sequencer_tb.sv ----
`timescale 1ns/1ps
module hrs_sequencer_tb;
	import hrs_pkg::*;
	localparam int RC = 20;
	localparam int EC = 200;
	localparam int AC = 200;
	localparam int QC = 50;
	logic        clk, reset, smbusModeSel, selfPowered, suspendReq, setAddrValid, setConfig, portPowerReq;
	logic        requestStart, requestDone, hostResetEn, eepromDone, smbusLoadDone, applyDone, usbBusReset;
	logic        operational, eepromFetch, smbusEnable, applyConfig, usbAttach, configFault, configured;
	logic        ttFlush, suspended, requestTimeout, downstreamReset;
	logic [6:0]  setAddrValue, deviceAddr;
	logic [2:0]  downstream_port_power_en;
	logic [15:0] loadDelay;
	int          n_fail = 0;
	int          check_count = 0;
	hrs_sequencer #(.RECOVERY_CYCLES(RC), .EEPROM_MAX_CYCLES(EC), .ATTACH_MAX_CYCLES(AC), .REQUEST_CYCLES(QC),
		.BUSPWR_CYCLES(EC)) hrs_sequencer_inst (.*);
	hrs_far_end hrs_far_end_inst (.*);
	always #20 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task results;
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic boot(input logic smb, input logic sp, input logic [15:0] dly, output int n);
		@(posedge clk);
		smbusModeSel <= smb;
		selfPowered  <= sp;
		loadDelay    <= dly;
		reset        <= 1'b1;
		repeat (26) @(posedge clk);
		reset <= 1'b0;
		n = 0;
		while (operational !== 1'b1 && n < 99)
		begin
			@(negedge clk);
			n++;
		end
		chk("recover", 1'b1, n <= RC + 3);
		chk("fetch", {!smb, smb}, {eepromFetch, smbusEnable});
		n = 0;
		while (usbAttach !== 1'b1 && n < 999)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic boot_case(input logic smb, sp, input logic [15:0] dly, input logic flt, input int lo);
		int n;
		boot(smb, sp, dly, n);
		chk("fault", flt, configFault);
		chk("attach", 1'b1, n >= lo && n <= lo + AC + 6);
	endtask
	task automatic t_modes;
		boot_case(1'b0, 1'b0, 16'h000a, 1'b0, 10);
		boot_case(1'b0, 1'b0, 16'h012c, 1'b1, EC);
		boot_case(1'b1, 1'b0, 16'h0032, 1'b0, 50);
		boot_case(1'b1, 1'b0, 16'h012c, 1'b1, EC);
		boot_case(1'b1, 1'b1, 16'h0190, 1'b0, 400);
	endtask
	task automatic t_request;
		int n;
		@(posedge clk);
		requestStart <= 1'b1;
		@(posedge clk);
		requestStart <= 1'b0;
		n = 0;
		while (requestTimeout !== 1'b1 && n < 99)
		begin
			@(negedge clk);
			n++;
		end
		chk("timeout", 1'b1, n >= QC - 2 && n <= QC + 2);
		// A request closed in time must raise no timeout
		@(posedge clk);
		requestStart <= 1'b1;
		@(posedge clk);
		requestStart <= 1'b0;
		repeat (5) @(posedge clk);
		requestDone <= 1'b1;
		@(posedge clk);
		requestDone <= 1'b0;
		n = 0;
		repeat (QC + 5)
		begin
			@(negedge clk);
			n += (requestTimeout === 1'b1);
		end
		chk("doneInTime", 32'h0, n);
	endtask
	task automatic t_bus_reset;
		@(posedge clk);
		setAddrValid <= 1'b1;
		setAddrValue <= 7'h05;
		setConfig    <= 1'b1;
		portPowerReq <= 1'b1;
		suspendReq   <= 1'b1;
		@(posedge clk);
		setAddrValid <= 1'b0;
		setConfig    <= 1'b0;
		// Power follows one edge after configured rises
		@(posedge clk);
		@(negedge clk);
		chk("setup", 11'h05f, {deviceAddr, downstream_port_power_en, configured});
		@(posedge clk);
		hostResetEn  <= 1'b1;
		while (usbBusReset !== 1'b1)
			@(negedge clk);
		@(negedge clk);
		chk("addr", DEFAULT_ADDR, deviceAddr);
		chk("unconf", 1'b0, configured);
		chk("power", PORT_PWR_OFF, downstream_port_power_en);
		chk("flush", 1'b1, ttFlush);
		chk("wake", 1'b0, suspended);
		chk("noFwd", 1'b0, downstreamReset);
		@(posedge clk);
		hostResetEn  <= 1'b0;
		suspendReq   <= 1'b0;
		portPowerReq <= 1'b0;
	endtask
	task automatic t_hw_reset;
		@(posedge clk);
		smbusModeSel <= 1'b1;
		loadDelay    <= 16'h03e8;
		reset        <= 1'b1;
		repeat (26) @(posedge clk);
		reset <= 1'b0;
		repeat (RC + 20) @(posedge clk);
		chk("midLoad", 1'b1, smbusEnable);
		reset <= 1'b1;
		@(negedge clk);
		chk("restart", 1'b0, smbusEnable | operational | usbAttach);
		boot_case(1'b0, 1'b0, 16'h000a, 1'b0, 10);
	endtask
	initial
	begin
		clk = 1'b0;
		reset = 1'b1;
		{smbusModeSel, selfPowered, suspendReq, setAddrValid, setConfig, portPowerReq} = 6'h0;
		{requestStart, requestDone, hostResetEn, setAddrValue, loadDelay} = 26'h0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_modes();
		t_request();
		t_bus_reset();
		t_hw_reset();
		results();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		results();
	end
endmodule
